/* logic/kil_keypad_latch.sv */
`timescale 1ns/100ps
`include "kil_cfg.svh"
module kil_keypad_latch
(
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  RST_I,
    input  wire logic [7:0]            PIN_I,
    input  wire kil_pkg::kil_port_cfg_t PORT_CFG_I,
    input  wire logic                  ENABLE_WR_I,
    input  wire logic [7:0]            ENABLE_DATA_I,
    input  wire logic                  SCR_WR_I,
    input  wire logic                  SCR_LEVEL_I,
    input  wire logic                  SCR_MASK_I,
    input  wire logic                  SCR_ACK_I,
    input  wire logic                  VEC_FETCH_I,
    input  wire logic                  BREAK_I,
    input  wire logic                  BREAK_CLR_EN_I,
    output logic [7:0]                 ENABLE_O,
    output logic                       LEVEL_O,
    output logic                       MASK_O,
    output logic                       ACK_RD_O,
    output kil_pkg::kil_status_t       STATUS_O,
    output logic [15:0]                VEC_ADDR_O,
    output logic [7:0]                 PULLUP_O,
    output logic [7:0]                 PIN_OE_O,
    output logic [7:0]                 PIN_OUT_O,
    output logic [7:0]                 PORT_RD_O
);
    import kil_pkg::*;

    logic [7:0] enable_ff;
    logic       level_ff;
    logic       mask_ff;
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic       any_low_prev_ff;
    logic       latch_ff;
    logic       any_low;
    logic       fall;
    logic       ack;
    logic       nxt_latch;
    logic       pending;

    ////////////////////////////////////////////////////////////////////////
    // any enabled input seen low
    function automatic logic enabled_low(input logic [7:0] en, input logic [7:0] lvl);
        enabled_low = |(en & ~lvl);
    endfunction : enabled_low

    ////////////////////////////////////////////////////////////////////////
    // control bits
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            enable_ff <= `KIL_ENABLE_RST;                   // [RULE21]
        else if (ENABLE_WR_I)
            enable_ff <= ENABLE_DATA_I;                     // [RULE1]
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            level_ff <= 1'b0;                               // [RULE13]
            mask_ff  <= 1'b0;                               // [RULE20]
        end
        else if (SCR_WR_I)
        begin
            level_ff <= SCR_LEVEL_I;                        // [RULE6]
            mask_ff  <= SCR_MASK_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchroniser
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            sync1_ff <= `KIL_SYNC_RST;
            sync2_ff <= `KIL_SYNC_RST;
        end
        else
        begin
            sync1_ff <= PIN_I;                              // [RULE23]
            sync2_ff <= sync1_ff;
        end
    end

    // combined low of enabled inputs is one event
    assign any_low = enabled_low(enable_ff, sync2_ff);     // [RULE3]
    assign fall    = any_low && !any_low_prev_ff;          // [RULE4]
    assign ack     = VEC_FETCH_I                           // [RULE8]
                     || (SCR_WR_I && SCR_ACK_I
                         && !(BREAK_I && !BREAK_CLR_EN_I)); // [RULE9] [RULE22]

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            any_low_prev_ff <= 1'b0;
        else
            any_low_prev_ff <= any_low;
    end

    ////////////////////////////////////////////////////////////////////////
    // request latch; a new fall wins over an acknowledge
    always_comb
    begin
        nxt_latch = latch_ff;
        if (ack)
            nxt_latch = 1'b0;                               // [RULE12]
        if (fall)
            nxt_latch = 1'b1;                               // [RULE10]
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            latch_ff <= 1'b0;                               // [RULE13]
        else
            latch_ff <= nxt_latch;
    end

    // level mode keeps the request while any enabled input is low
    assign pending = latch_ff || (level_ff && any_low);    // [RULE5] [RULE7]

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign ENABLE_O         = enable_ff;
    assign LEVEL_O          = level_ff;
    assign MASK_O           = mask_ff;
    assign ACK_RD_O         = 1'b0;                         // [RULE19]
    assign STATUS_O.pending = pending;                      // [RULE14]
    assign STATUS_O.irq     = pending && !mask_ff;          // [RULE20]
    assign VEC_ADDR_O       = `KIL_VEC_HI;                  // [RULE11]
    assign PULLUP_O         = enable_ff;                    // [RULE2]
    assign PIN_OE_O         = PORT_CFG_I.dir & ~enable_ff;  // [RULE15]
    assign PIN_OUT_O        = PORT_CFG_I.data;

    genvar g;
    generate
        for (g = 0; g < `KIL_NUM_PINS; g = g + 1)
        begin : g_rd
            assign PORT_RD_O[g] = PORT_CFG_I.dir[g] ? PORT_CFG_I.data[g]
                                                    : sync2_ff[g]; // [RULE15]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_reset_clears: assert property (@(posedge CLK_SYS_I) // [RULE13]
        RST_I |=> !latch_ff && !level_ff && !mask_ff && enable_ff == 8'h00)
        else $error("reset left state set");
    a_fall_latches: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE3]
        fall |=> STATUS_O.pending)
        else $error("fall did not latch");
    a_edge_ack_clr: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE12]
        (ack && !fall && !level_ff && !SCR_WR_I) |=> !STATUS_O.pending)
        else $error("ack did not clear");
    a_level_holds: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE5]
        (level_ff && any_low) |-> STATUS_O.pending)
        else $error("level request dropped");
    a_no_refall: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE4]
        (any_low_prev_ff && !latch_ff && !level_ff) |=> !latch_ff)
        else $error("second fall latched");
    a_mask_gates: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE20]
        mask_ff |-> !STATUS_O.irq)
        else $error("masked request passed");
    a_break_ack: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE22]
        (latch_ff && BREAK_I && !BREAK_CLR_EN_I && !VEC_FETCH_I) |=> latch_ff)
        else $error("break ack cleared");
    a_pullup_en: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE2]
        (PULLUP_O == enable_ff) && ((PIN_OE_O & enable_ff) == 8'h00))
        else $error("pullup or direction wrong");
    a_sync_delay: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE23]
        $fell(PIN_I[0]) && enable_ff[0] && !RST_I ##1 enable_ff[0] |=> sync2_ff[0] == 1'b0)
        else $error("sync depth wrong");

    ////////////////////////////////////////////////////////////////////////
    // register loads, clearing and outputs
    a_enable_load: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE1]
        ENABLE_WR_I |=> enable_ff == $past(ENABLE_DATA_I))
        else $error("enable write lost");
    a_scr_load: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE6]
        SCR_WR_I |=> (level_ff == $past(SCR_LEVEL_I)) && (mask_ff == $past(SCR_MASK_I)))
        else $error("control write lost");
    a_soft_ack: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE9]
        (SCR_WR_I && SCR_ACK_I && !(BREAK_I && !BREAK_CLR_EN_I) && !fall && !SCR_LEVEL_I)
        |=> !STATUS_O.pending)
        else $error("software ack did not clear");
    a_fetch_clear: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE8]
        (VEC_FETCH_I && !fall) |=> !latch_ff)
        else $error("vector fetch did not clear");
    a_latch_holds: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE7]
        (latch_ff && !ack) |=> latch_ff)
        else $error("request dropped without ack");
    a_level_clear: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE7]
        (level_ff && !latch_ff && !enabled_low(enable_ff, sync2_ff)) |-> !STATUS_O.pending)
        else $error("level request stuck");
    a_pend_masked: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE14]
        (latch_ff && mask_ff) |-> STATUS_O.pending)
        else $error("pending hidden by mask");
    a_pend_unmask: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE11]
        (STATUS_O.pending && !mask_ff) |-> STATUS_O.irq)
        else $error("unmasked request not raised");
    a_irq_pend: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE20]
        STATUS_O.irq |-> STATUS_O.pending)
        else $error("request without pending");
    a_ack_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE19]
        ACK_RD_O == 1'b0)
        else $error("ack bit read back set");
    a_vec_fixed: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE11]
        VEC_ADDR_O == `KIL_VEC_HI)
        else $error("vector address wrong");
    a_port_read: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE15]
        PORT_RD_O == ((PORT_CFG_I.dir & PORT_CFG_I.data) | (~PORT_CFG_I.dir & sync2_ff)))
        else $error("port read path wrong");
    a_pin_out: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE15]
        PIN_OUT_O == PORT_CFG_I.data)
        else $error("pin output data wrong");

    c_edge_req: cover property (@(posedge CLK_SYS_I) fall && !level_ff);
    c_level_req: cover property (@(posedge CLK_SYS_I) level_ff && any_low && !latch_ff);
    c_ack_clr: cover property (@(posedge CLK_SYS_I) latch_ff && ack);
    c_irq_out: cover property (@(posedge CLK_SYS_I) STATUS_O.irq);
    c_break_hold: cover property (@(posedge CLK_SYS_I) latch_ff && BREAK_I && SCR_WR_I && SCR_ACK_I);
endmodule : kil_keypad_latch

/* logic/kil_cfg.svh */
// Function
// RULE1: eight keypad inputs, each with its own enable, one shared mask.
// RULE2: an enabled pin also gets its pull-up switched on.
// RULE3: request latches when enabled inputs go low after all were high.
// RULE4: edge-only mode ignores a fall while another enabled input is low.
// RULE5: edge-and-level mode requests while any enabled input stays low.
// RULE6: sensitivity bit set means edge and level, clear means edge only.
// RULE7: level mode clears only after acknowledge and all inputs high.
// RULE8: a keypad vector fetch acknowledges and clears the request.
// RULE9: writing one to the acknowledge bit acknowledges like a fetch.
// RULE10: a fall after an acknowledge latches a fresh request.
// RULE11: unmasked pending request makes the CPU take vector $FFE0/$FFE1.
// RULE12: edge-only mode clears the request at once on acknowledge.
// RULE13: reset clears request and sensitivity bit even with a pin low.
// RULE14: pending flag shows the latched request regardless of mask.
// RULE15: enable forces the pin to input; pin read needs direction zero.
// RULE16: software masks, enables, acknowledges, then unmasks.
// RULE17: level mode software waits for the load before acknowledging.
// RULE18: software may drive pins high as outputs before enabling them.
// RULE19: acknowledge bit is write-only, reads zero, cleared by reset.
// RULE20: mask bit blocks the request from the CPU; reset clears it.
// RULE21: reset clears all eight enable bits.
// RULE22: in break with break-clear zero, software acknowledge does nothing.
// RULE23: each input is synchronised to the bus clock before detection.
`ifndef KIL_CFG_SVH
`define KIL_CFG_SVH
`define KIL_NUM_PINS   8
`define KIL_VEC_HI     16'hffe0
`define KIL_VEC_LO     16'hffe1
`define KIL_ENABLE_RST 8'h00
`define KIL_SYNC_RST   8'hff
`endif

/* logic/kil_pkg.sv */
package kil_pkg;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] data;
    } kil_port_cfg_t;
    typedef struct packed {
        logic pending;
        logic irq;
    } kil_status_t;
endpackage : kil_pkg

/* sim/kil_keypad_switches.sv */
`timescale 1ns/100ps
module kil_keypad_switches
(
    input  wire logic       clk_i,
    input  wire logic [7:0] press_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] out_i,
    output logic      [7:0] pin_o
);
    logic tog_ff = 1'b0;
    always_ff @(posedge clk_i) tog_ff <= ~tog_ff;
    // pulled-up pins idle high, floating ones wander each cycle
    assign pin_o = (oe_i & out_i) | (~oe_i & ~press_i & (pullup_i | {8{tog_ff}}));
endmodule : kil_keypad_switches

/* sim/kil_keypad_latch_bench.sv */
`timescale 1ns/100ps
module kil_keypad_latch_bench;
    import kil_pkg::*;
    logic          clk = 0, rst = 1, en_wr = 0, scr_wr = 0, lvl = 0, msk = 0, ack = 0;
    logic          fetch = 0, brk = 0, bce = 0;
    logic [7:0]    en_d = 0, press = 0, pin, en, pu, oe, po, prd;
    logic          lvl_o, msk_o, ack_o;
    kil_status_t   st;
    logic [15:0]   vec;
    kil_port_cfg_t cfg = '{dir: 8'hff, data: 8'ha5};
    int            n_fail = 0, n_tests = 0, cycles = 0;
    always #20 clk = ~clk;
    kil_keypad_switches i_kil_keypad_switches (.clk_i(clk), .press_i(press), .pullup_i(pu),
        .oe_i(oe), .out_i(po), .pin_o(pin));
    kil_keypad_latch i_kil_keypad_latch (.CLK_SYS_I(clk), .RST_I(rst), .PIN_I(pin),
        .PORT_CFG_I(cfg), .ENABLE_WR_I(en_wr), .ENABLE_DATA_I(en_d), .SCR_WR_I(scr_wr),
        .SCR_LEVEL_I(lvl), .SCR_MASK_I(msk), .SCR_ACK_I(ack), .VEC_FETCH_I(fetch),
        .BREAK_I(brk), .BREAK_CLR_EN_I(bce), .ENABLE_O(en), .LEVEL_O(lvl_o), .MASK_O(msk_o),
        .ACK_RD_O(ack_o), .STATUS_O(st), .VEC_ADDR_O(vec), .PULLUP_O(pu), .PIN_OE_O(oe),
        .PIN_OUT_O(po), .PORT_RD_O(prd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_en(input logic [7:0] d);
        @(posedge clk);
        en_wr <= 1'b1;
        en_d  <= d;
        @(posedge clk);
        en_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wr_en
    task automatic wr_scr(input logic l, input logic m, input logic a);
        @(posedge clk);
        scr_wr <= 1'b1;
        lvl    <= l;
        msk    <= m;
        ack    <= a;
        @(posedge clk);
        scr_wr <= 1'b0;
        ack    <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wr_scr
    task automatic key(input logic [7:0] p);
        @(posedge clk);
        press <= p;
        repeat (5) @(posedge clk);
    endtask : key
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_edge;
        wr_scr(0, 1, 0);
        wr_en(8'h03);
        wr_scr(0, 1, 1);
        wr_scr(0, 0, 0);
        chk(pu, 8'h03);
        chk(oe, 8'hfc);
        chk(prd, 8'ha5);
        chk(po, 8'ha5);
        key(8'h01);
        chk(st, 2'b11);
        wr_scr(0, 0, 1);
        chk(st, 2'b00);
        key(8'h03);
        chk(st, 2'b00);
        key(8'h00);
        key(8'h02);
        chk(st, 2'b11);
        @(posedge clk);
        fetch <= 1'b1;
        @(posedge clk);
        fetch <= 1'b0;
        repeat (2) @(posedge clk);
        chk(st, 2'b00);
        wr_scr(0, 1, 0);
        key(8'h00);
        key(8'h01);
        chk(st, 2'b10);
        wr_scr(0, 0, 0);
        chk(st, 2'b11);
    endtask : t_edge
    task automatic t_level;
        wr_scr(1, 0, 1);
        chk(lvl_o, 1'b1);
        chk(st, 2'b11);
        key(8'h00);
        chk(st, 2'b00);
        key(8'h02);
        repeat (8) @(posedge clk);
        chk(st, 2'b11);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({en, lvl_o, msk_o, ack_o, st}, 0);
        key(8'h00);
    endtask : t_level
    task automatic t_break;
        wr_en(8'h01);
        wr_scr(0, 0, 1);
        key(8'h01);
        brk <= 1'b1;
        wr_scr(0, 0, 1);
        chk(st, 2'b11);
        bce <= 1'b1;
        wr_scr(0, 0, 1);
        chk(st, 2'b00);
    endtask : t_break
    task automatic t_port;
        brk <= 1'b0;
        key(8'h00);
        cfg <= '{dir: 8'hff, data: 8'hff};
        wr_en(8'hff);
        chk(st, 2'b00);
        chk(po, 8'hff);
        cfg <= '{dir: 8'h0f, data: 8'h00};
        key(8'h20);
        chk(oe, 8'h00);
        chk(prd, 8'hd0);
        chk(st, 2'b11);
    endtask : t_port
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            complete_run();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({en, lvl_o, msk_o, ack_o, st}, 0);
        chk(vec, 16'hffe0);
        t_edge();
        t_level();
        t_break();
        t_port();
        complete_run();
    end
endmodule : kil_keypad_latch_bench
